// ### rtl/port_e_f_alternate_override.sv
// Alternate-function override logic for the pin-group port (E) and the
// analog-input port (F), with port registers on Avalon-MM and a TAP.
// Assumes pins and peripheral signals are synchronous to mclk.
//
// Behaviour
// - Enabled timer compare C drives pin 5 of port E when direction is output.
// - Enabled timer compare B drives pin 4 of port E when direction is output.
// - Enabled timer compare A drives pin 3 of port E when direction is output.
// - Enabled external interrupt on pins 7..4 forces digital input enable on.
// - Pin 7 input feeds timer capture trigger and external interrupt 7.
// - Pin 6 input feeds timer counting source and external interrupt 6.
// - Pin 2 carries serial clock in sync mode; direction bit picks in/out.
// - Transmitter enabled forces pin 1 output, pull-up off, transmit data out.
// - Receiver enabled forces pin 0 input; its input feeds the receiver.
// - Forced-input pin 0 pull-up is port bit and not global disable.
// - Serial programming uses pin 1 as data out, pin 0 as data in.
// - Legacy mode disables timer capture, clock, compare and serial clock pins.
// - Legacy mode makes all of port F input only, apart from test data out (pin 6) while scan is enabled and shifting.
// - Scan enabled keeps pull-ups on data in, mode select, test clock, even in reset.
// - Scan enabled takes port F pins 7..4 away from general I/O.
// - Test data out driven only in shift-IR and shift-DR states.
// - Test data in is shifted into instruction or bypass register.
// - TAP state machine advances on sampled mode select.
// - TAP shifting and state changes happen on test clock edges only, apart from the forced reset while scan is disabled.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module port_e_f_alternate_override (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Avalon-MM register slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Mode and fuse levels.
  input  wire logic        legacy_mode,
  input  wire logic        scan_enable_fuse,
  input  wire logic        sleep_active,
  input  wire logic        prog_mode_active,
  // Timer side.
  input  wire logic        timer_c_cmp_a_en,
  input  wire logic        timer_c_cmp_b_en,
  input  wire logic        timer_c_cmp_c_en,
  input  wire logic        timer_c_cmp_a_out,
  input  wire logic        timer_c_cmp_b_out,
  input  wire logic        timer_c_cmp_c_out,
  output logic             timer_c_capture_in,
  output logic             timer_c_count_src,
  // External interrupt side, enables for pins 7..4.
  input  wire logic [3:0]  ext_irq_enable,
  output logic             ext_irq_seven,
  output logic             ext_irq_six,
  output logic             ext_irq_five,
  output logic             ext_irq_four,
  // Serial side.
  input  wire logic        serial_tx_enable,
  input  wire logic        serial_rx_enable,
  input  wire logic        serial_sync_select,
  input  wire logic        serial_tx_line,
  input  wire logic        serial_sync_clock,
  output logic             serial_rx_line,
  output logic             serial_clock_in,
  // Serial programming side.
  input  wire logic        prog_data_out,
  output logic             prog_data_in,
  // Port E pads.
  input  wire logic [7:0]  pe_in,
  output logic [7:0]       pe_out,
  output logic [7:0]       pe_oe,
  output logic [7:0]       pe_pullup,
  // Port F pads.
  input  wire logic [7:0]  pf_in,
  output logic [7:0]       pf_out,
  output logic [7:0]       pf_oe,
  output logic [7:0]       pf_pullup
);

  typedef struct packed {
    logic [7:0]                      port_e;
    logic [7:0]                      dir_e;
    logic [7:0]                      port_f;
    logic [7:0]                      dir_f;
    logic                            global_pullup_disable;
    logic                            ack;
    logic [31:0]                     rdata;
    logic [7:0]                      pin_e;
    logic [7:0]                      pin_f;
    logic                            tck_s1;
    logic                            tck_s2;
    logic                            tck_d;
    logic                            tms_s1;
    logic                            tms_s2;
    logic                            tdi_s1;
    logic                            tdi_s2;
    port_ef_pkg::tap_state_t         tap;
    logic [port_ef_pkg::IR_W-1:0]    ir;
    logic [port_ef_pkg::IR_W-1:0]    ir_sh;
    logic                            byp;
    logic                            tdo;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // Override signal sets per pin.
  logic [7:0] e_pullup_override_en, e_puov, e_direction_override_en, e_ddov, e_value_override_en, e_pvov, e_input_enable_override_en, e_input_enable_override_val;
  logic [7:0] f_pullup_override_en, f_puov, f_direction_override_en, f_ddov, f_value_override_en, f_pvov, f_input_enable_override_en, f_input_enable_override_val;
  logic [7:0] pe_die;
  logic [7:0] pf_die;
  logic       cmp_a_on;
  logic       cmp_b_on;
  logic       cmp_c_on;
  logic       sync_on;
  logic       tx_on;
  logic       rx_on;
  logic       shifting;
  logic       tck_rise;
  logic       tck_fall;
  logic       bus_req;
  logic       bus_take;
  logic [31:0] rd_mux;

  // Legacy mode removes the timer and serial clock pin functions.
  assign cmp_a_on = timer_c_cmp_a_en & ~legacy_mode;
  assign cmp_b_on = timer_c_cmp_b_en & ~legacy_mode;
  assign cmp_c_on = timer_c_cmp_c_en & ~legacy_mode;
  assign sync_on  = serial_sync_select & ~legacy_mode;
  // Serial programming takes pins 1 and 0 ahead of the serial port.
  assign tx_on    = serial_tx_enable | prog_mode_active;
  assign rx_on    = serial_rx_enable | prog_mode_active;
  assign shifting = (st_reg.tap == port_ef_pkg::TAP_SHIR) | (st_reg.tap == port_ef_pkg::TAP_SHDR);

  always_comb begin
    e_pullup_override_en  = '0;
    e_puov  = '0;
    e_direction_override_en  = '0;
    e_ddov  = '0;
    e_value_override_en  = '0;
    e_pvov  = '0;
    e_input_enable_override_en = '0;
    e_input_enable_override_val = '0;
    e_value_override_en[port_ef_pkg::PE_CMPC] = cmp_c_on;
    e_pvov[port_ef_pkg::PE_CMPC] = timer_c_cmp_c_out;
    e_value_override_en[port_ef_pkg::PE_CMPB] = cmp_b_on;
    e_pvov[port_ef_pkg::PE_CMPB] = timer_c_cmp_b_out;
    e_value_override_en[port_ef_pkg::PE_CMPA] = cmp_a_on;
    e_pvov[port_ef_pkg::PE_CMPA] = timer_c_cmp_a_out;
    e_value_override_en[port_ef_pkg::PE_XCK]  = sync_on;
    e_pvov[port_ef_pkg::PE_XCK]  = serial_sync_clock;
    e_input_enable_override_en[7:4] = ext_irq_enable;
    e_input_enable_override_val[7:4] = 4'hF;
    e_pullup_override_en[port_ef_pkg::PE_TX] = tx_on;
    e_direction_override_en[port_ef_pkg::PE_TX] = tx_on;
    e_ddov[port_ef_pkg::PE_TX] = 1'b1;
    e_value_override_en[port_ef_pkg::PE_TX] = tx_on;
    e_pvov[port_ef_pkg::PE_TX] = prog_mode_active ? prog_data_out : serial_tx_line;
    e_pullup_override_en[port_ef_pkg::PE_RX] = rx_on;
    e_puov[port_ef_pkg::PE_RX] = st_reg.port_e[port_ef_pkg::PE_RX] & ~st_reg.global_pullup_disable;
    e_direction_override_en[port_ef_pkg::PE_RX] = rx_on;
    f_pullup_override_en  = '0;
    f_puov  = '0;
    f_direction_override_en  = legacy_mode ? 8'hFF : 8'h00;
    f_ddov  = '0;
    f_value_override_en  = '0;
    f_pvov  = '0;
    f_input_enable_override_en = '0;
    f_input_enable_override_val = '0;
    f_pullup_override_en[7:4] = {4{scan_enable_fuse}};
    f_direction_override_en[7:4] = {4{scan_enable_fuse}} | f_direction_override_en[7:4];
    f_input_enable_override_en[7:4] = {4{scan_enable_fuse}};
    f_puov[port_ef_pkg::PF_TDI] = 1'b1;
    f_puov[port_ef_pkg::PF_TMS] = 1'b1;
    f_puov[port_ef_pkg::PF_TCK] = 1'b1;
    f_ddov[port_ef_pkg::PF_TDO] = scan_enable_fuse & shifting;
    f_value_override_en[port_ef_pkg::PF_TDO] = scan_enable_fuse;
    f_pvov[port_ef_pkg::PF_TDO] = st_reg.tdo;
  end

  // Per-pin override muxes; pull-ups stay combinational so they hold through reset.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pe_pullup[gi] = e_pullup_override_en[gi] ? e_puov[gi]
                           : (st_reg.port_e[gi] & ~st_reg.dir_e[gi] & ~st_reg.global_pullup_disable);
      assign pe_oe[gi]     = e_direction_override_en[gi] ? e_ddov[gi] : st_reg.dir_e[gi];
      assign pe_out[gi]    = e_value_override_en[gi] ? e_pvov[gi] : st_reg.port_e[gi];
      assign pe_die[gi]    = e_input_enable_override_en[gi] ? e_input_enable_override_val[gi] : ~sleep_active;
      assign pf_pullup[gi] = f_pullup_override_en[gi] ? f_puov[gi]
                           : (st_reg.port_f[gi] & ~(st_reg.dir_f[gi] & ~legacy_mode) & ~st_reg.global_pullup_disable);
      assign pf_oe[gi]     = f_direction_override_en[gi] ? f_ddov[gi] : st_reg.dir_f[gi];
      assign pf_out[gi]    = f_value_override_en[gi] ? f_pvov[gi] : st_reg.port_f[gi];
      assign pf_die[gi]    = f_input_enable_override_en[gi] ? f_input_enable_override_val[gi] : ~sleep_active;
    end
  endgenerate

  // Peripheral inputs come from the registered, enable-gated pin values.
  assign ext_irq_seven      = st_reg.pin_e[7];
  assign ext_irq_six        = st_reg.pin_e[6];
  assign ext_irq_five       = st_reg.pin_e[5];
  assign ext_irq_four       = st_reg.pin_e[4];
  assign timer_c_capture_in = st_reg.pin_e[port_ef_pkg::PE_CAP] & ~legacy_mode;
  assign timer_c_count_src  = st_reg.pin_e[port_ef_pkg::PE_CNT] & ~legacy_mode;
  assign serial_clock_in    = st_reg.pin_e[port_ef_pkg::PE_XCK] & sync_on;
  assign serial_rx_line     = st_reg.pin_e[port_ef_pkg::PE_RX];
  assign prog_data_in       = st_reg.pin_e[port_ef_pkg::PE_RX];

  // Bus: one wait cycle, then the request is taken.
  assign bus_req         = avs_read | avs_write;
  assign bus_take        = bus_req & st_reg.ack;
  assign avs_waitrequest = bus_req & ~st_reg.ack;
  assign avs_readdata    = st_reg.rdata;

  assign tck_rise = st_reg.tck_s2 & ~st_reg.tck_d;
  assign tck_fall = ~st_reg.tck_s2 & st_reg.tck_d;

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      port_ef_pkg::OFS_PORT_E: rd_mux[7:0] = st_reg.port_e;
      port_ef_pkg::OFS_DIR_E:  rd_mux[7:0] = st_reg.dir_e;
      port_ef_pkg::OFS_PORT_F: rd_mux[7:0] = st_reg.port_f;
      port_ef_pkg::OFS_DIR_F:  rd_mux[7:0] = st_reg.dir_f;
      port_ef_pkg::OFS_CTRL:   rd_mux[port_ef_pkg::CTRL_PUD_BIT] = st_reg.global_pullup_disable;
      port_ef_pkg::OFS_PIN_E:  rd_mux[7:0] = st_reg.pin_e;
      port_ef_pkg::OFS_PIN_F:  rd_mux[7:0] = st_reg.pin_f;
      port_ef_pkg::OFS_TAP: begin
        rd_mux[15:0] = st_reg.tap;
        rd_mux[port_ef_pkg::TAP_IR_LSB +: port_ef_pkg::IR_W] = st_reg.ir;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    st_next        = st_reg;
    st_next.ack    = bus_req & ~st_reg.ack;
    st_next.pin_e  = pe_in & pe_die;
    st_next.pin_f  = pf_in & pf_die;
    if (avs_read & ~st_reg.ack) begin
      st_next.rdata = rd_mux;
    end
    if (avs_write & bus_take) begin
      case (avs_address)
        port_ef_pkg::OFS_PORT_E: st_next.port_e = avs_writedata[7:0];
        port_ef_pkg::OFS_DIR_E:  st_next.dir_e  = avs_writedata[7:0];
        port_ef_pkg::OFS_PORT_F: st_next.port_f = avs_writedata[7:0];
        port_ef_pkg::OFS_DIR_F:  st_next.dir_f  = avs_writedata[7:0];
        port_ef_pkg::OFS_CTRL:   st_next.global_pullup_disable    = avs_writedata[port_ef_pkg::CTRL_PUD_BIT];
        default:                 st_next.global_pullup_disable    = st_reg.global_pullup_disable;
      endcase
    end
    // Test pins are sampled through two flops before any edge logic.
    st_next.tck_s1 = pf_in[port_ef_pkg::PF_TCK];
    st_next.tck_s2 = st_reg.tck_s1;
    st_next.tck_d  = st_reg.tck_s2;
    st_next.tms_s1 = pf_in[port_ef_pkg::PF_TMS];
    st_next.tms_s2 = st_reg.tms_s1;
    st_next.tdi_s1 = pf_in[port_ef_pkg::PF_TDI];
    st_next.tdi_s2 = st_reg.tdi_s1;
    if (!scan_enable_fuse) begin
      st_next.tap = port_ef_pkg::TAP_RESET;
      st_next.ir  = port_ef_pkg::IR_RST;
    end else if (tck_rise) begin
      case (st_reg.tap)
        port_ef_pkg::TAP_CAPIR: st_next.ir_sh = port_ef_pkg::IR_CAPTURE;
        port_ef_pkg::TAP_SHIR:  st_next.ir_sh = {st_reg.tdi_s2, st_reg.ir_sh[port_ef_pkg::IR_W-1:1]};
        port_ef_pkg::TAP_UPIR:  st_next.ir    = st_reg.ir_sh;
        port_ef_pkg::TAP_CAPDR: st_next.byp   = 1'b0;
        port_ef_pkg::TAP_SHDR:  st_next.byp   = st_reg.tdi_s2;
        port_ef_pkg::TAP_RESET: st_next.ir    = port_ef_pkg::IR_RST;
        default:                st_next.byp   = st_reg.byp;
      endcase
      case (st_reg.tap)
        port_ef_pkg::TAP_RESET: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_RESET : port_ef_pkg::TAP_IDLE;
        port_ef_pkg::TAP_IDLE:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_SELDR : port_ef_pkg::TAP_IDLE;
        port_ef_pkg::TAP_SELDR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_SELIR : port_ef_pkg::TAP_CAPDR;
        port_ef_pkg::TAP_CAPDR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX1DR : port_ef_pkg::TAP_SHDR;
        port_ef_pkg::TAP_SHDR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX1DR : port_ef_pkg::TAP_SHDR;
        port_ef_pkg::TAP_EX1DR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_UPDR : port_ef_pkg::TAP_PSDR;
        port_ef_pkg::TAP_PSDR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX2DR : port_ef_pkg::TAP_PSDR;
        port_ef_pkg::TAP_EX2DR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_UPDR : port_ef_pkg::TAP_SHDR;
        port_ef_pkg::TAP_UPDR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_SELDR : port_ef_pkg::TAP_IDLE;
        port_ef_pkg::TAP_SELIR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_RESET : port_ef_pkg::TAP_CAPIR;
        port_ef_pkg::TAP_CAPIR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX1IR : port_ef_pkg::TAP_SHIR;
        port_ef_pkg::TAP_SHIR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX1IR : port_ef_pkg::TAP_SHIR;
        port_ef_pkg::TAP_EX1IR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_UPIR : port_ef_pkg::TAP_PSIR;
        port_ef_pkg::TAP_PSIR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_EX2IR : port_ef_pkg::TAP_PSIR;
        port_ef_pkg::TAP_EX2IR: st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_UPIR : port_ef_pkg::TAP_SHIR;
        port_ef_pkg::TAP_UPIR:  st_next.tap = st_reg.tms_s2 ? port_ef_pkg::TAP_SELDR : port_ef_pkg::TAP_IDLE;
        default:                st_next.tap = port_ef_pkg::TAP_RESET;
      endcase
    end else if (tck_fall) begin
      // Output data changes on the falling test clock edge.
      st_next.tdo = (st_reg.tap == port_ef_pkg::TAP_SHIR) ? st_reg.ir_sh[0] : st_reg.byp;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg        <= '0;
      st_reg.port_e <= port_ef_pkg::PORT_RST;
      st_reg.dir_e  <= port_ef_pkg::DIR_RST;
      st_reg.port_f <= port_ef_pkg::PORT_RST;
      st_reg.dir_f  <= port_ef_pkg::DIR_RST;
      st_reg.tap    <= port_ef_pkg::TAP_RESET;
      st_reg.ir     <= port_ef_pkg::IR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_cmp_c_pin: assert property (cmp_c_on |-> pe_out[5] == timer_c_cmp_c_out)
    else $error("Compare C not on pin 5.");
  chk_cmp_b_pin: assert property (cmp_b_on |-> pe_out[4] == timer_c_cmp_b_out)
    else $error("Compare B not on pin 4.");
  chk_cmp_a_pin: assert property (cmp_a_on |-> pe_out[3] == timer_c_cmp_a_out)
    else $error("Compare A not on pin 3.");
  chk_irq_input_alive: assert property (ext_irq_enable[3] && sleep_active
      |=> ext_irq_seven == $past(pe_in[7]))
    else $error("Interrupt input lost in sleep.");
  chk_capture_route: assert property (!legacy_mode && $past(pe_die[7])
      |-> timer_c_capture_in == $past(pe_in[7]))
    else $error("Capture input not routed.");
  chk_tx_force: assert property (serial_tx_enable && !prog_mode_active
      |-> pe_oe[1] && !pe_pullup[1] && pe_out[1] == serial_tx_line)
    else $error("Transmit pin not forced.");
  chk_rx_pullup: assert property (rx_on |-> !pe_oe[0]
      && pe_pullup[0] == (st_reg.port_e[0] && !st_reg.global_pullup_disable))
    else $error("Receive pin override wrong.");
  chk_legacy_f_input: assert property (legacy_mode && !scan_enable_fuse |-> pf_oe == 8'h00)
    else $error("Port F driven in legacy mode.");
  chk_tdo_tristate: assert property (scan_enable_fuse && !shifting |-> !pf_oe[6])
    else $error("Test data out driven outside shift.");
  chk_tap_hold: assert property (scan_enable_fuse && !tck_rise |=> $stable(st_reg.tap))
    else $error("TAP moved without test clock edge.");
  chk_bus_answer: assert property (bus_req && !st_reg.ack |=> !avs_waitrequest)
    else $error("Bus answer late.");
  chk_count_route: assert property (!legacy_mode && $past(pe_die[6])
      |-> timer_c_count_src == $past(pe_in[6]))
    else $error("Count source not routed.");
  chk_sync_clock_pin: assert property (sync_on |-> pe_out[2] == serial_sync_clock)
    else $error("Serial clock not on pin 2.");
  chk_rx_feed: assert property (!sleep_active |=> serial_rx_line == $past(pe_in[0]))
    else $error("Receive input not routed.");
  chk_prog_pins: assert property (prog_mode_active |-> pe_oe[1] && pe_out[1] == prog_data_out)
    else $error("Programming data not on pin 1.");
  chk_legacy_pins: assert property (legacy_mode |-> !timer_c_capture_in && !timer_c_count_src
      && !serial_clock_in && pe_out[5:2] == st_reg.port_e[5:2])
    else $error("Timer pin active in legacy mode.");
  chk_scan_pullups: assert property (disable iff (1'b0) scan_enable_fuse
      |-> pf_pullup[7] && pf_pullup[5] && pf_pullup[4])
    else $error("Scan pull-ups off.");
  chk_scan_pins_taken: assert property (scan_enable_fuse |-> !pf_oe[7] && !pf_oe[5] && !pf_oe[4]
      ##1 st_reg.pin_f[7:4] == 4'h0)
    else $error("Scan pins left in general use.");
  chk_ir_shift_in: assert property (scan_enable_fuse && tck_rise && st_reg.tap == port_ef_pkg::TAP_SHIR
      |=> st_reg.ir_sh[port_ef_pkg::IR_W-1] == $past(st_reg.tdi_s2))
    else $error("Test data in not shifted.");

  cov_tx_active: cover property (serial_tx_enable ##1 pe_oe[1]);
  cov_shift_ir: cover property (st_reg.tap == port_ef_pkg::TAP_SHIR && pf_oe[6]);
  cov_shift_dr: cover property (st_reg.tap == port_ef_pkg::TAP_SHDR && tck_rise);
  cov_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule

`default_nettype wire

// ### rtl/port_ef_pkg.sv
// Shared constants for the port E / port F alternate-function override block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package port_ef_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_PORT_E = 5'h00;
  localparam logic [4:0] OFS_DIR_E  = 5'h04;
  localparam logic [4:0] OFS_PORT_F = 5'h08;
  localparam logic [4:0] OFS_DIR_F  = 5'h0C;
  localparam logic [4:0] OFS_CTRL   = 5'h10;
  localparam logic [4:0] OFS_PIN_E  = 5'h14;
  localparam logic [4:0] OFS_PIN_F  = 5'h18;
  localparam logic [4:0] OFS_TAP    = 5'h1C;

  // Field positions.
  localparam int CTRL_PUD_BIT = 0;
  localparam int TAP_IR_LSB   = 16;

  // Reset values.
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;

  // Pin positions on port E.
  localparam int PE_RX   = 0;
  localparam int PE_TX   = 1;
  localparam int PE_XCK  = 2;
  localparam int PE_CMPA = 3;
  localparam int PE_CMPB = 4;
  localparam int PE_CMPC = 5;
  localparam int PE_CNT  = 6;
  localparam int PE_CAP  = 7;
  localparam int PE_IRQ_LO = 4;

  // Pin positions on port F.
  localparam int PF_TCK = 4;
  localparam int PF_TMS = 5;
  localparam int PF_TDO = 6;
  localparam int PF_TDI = 7;

  // Instruction register.
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RST     = 4'hF;

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE  = 16'h0002,
    TAP_SELDR = 16'h0004, TAP_CAPDR = 16'h0008,
    TAP_SHDR  = 16'h0010, TAP_EX1DR = 16'h0020,
    TAP_PSDR  = 16'h0040, TAP_EX2DR = 16'h0080,
    TAP_UPDR  = 16'h0100, TAP_SELIR = 16'h0200,
    TAP_CAPIR = 16'h0400, TAP_SHIR  = 16'h0800,
    TAP_EX1IR = 16'h1000, TAP_PSIR  = 16'h2000,
    TAP_EX2IR = 16'h4000, TAP_UPIR  = 16'h8000
  } tap_state_t;

endpackage

// ### tb/far_side_model.sv
// Model of the on-chip peripherals behind the pin mux: timer compare values,
// transmit data, generated serial clock and programming data out.
// Assumes mclk and sys_rst of the block; outputs move every cycle after reset.
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Peripheral levels toward the block.
  output logic      cmp_a,
  output logic      cmp_b,
  output logic      cmp_c,
  output logic      tx_line,
  output logic      sync_clock,
  output logic      prog_out
);
  logic [7:0] lfsr_reg;
  // A shifting pattern keeps stale values from passing for fresh ones.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) lfsr_reg <= 8'h5A;
    else lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
  end
  assign {cmp_a, cmp_b, cmp_c, tx_line, sync_clock, prog_out} = lfsr_reg[5:0];
endmodule
`default_nettype wire

// ### tb/tb_port_e_f_alternate_override.sv
// Self-checking bench for the port E / port F override block.
// Assumes the peripheral model in far_side_model.sv; TAP pins are driven here.
`timescale 1ns/100ps
`default_nettype none
module tb_port_e_f_alternate_override;
  logic        mclk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, legacy = 1'b0, fuse = 1'b1, sleep = 1'b0, prog = 1'b0;
  logic        a_en = 1'b0, b_en = 1'b0, c_en = 1'b0, tx_en = 1'b0, rx_en = 1'b0, sync = 1'b0;
  logic        cmp_a, cmp_b, cmp_c, tx_line, sync_clock, prog_out, pu_off = 1'b0;
  logic        i7, i6, i5, i4, cap, cnt, rx_o, clk_in, prog_in;
  logic [3:0]  irq_en = 4'h0, g;
  logic [7:0]  pe_in = 8'h00, pf_in = 8'h00, pe_out, pe_oe, pe_pu, pf_out, pf_oe, pf_pu;
  logic [7:0]  port_e = 8'h00, dir_e = 8'h00, port_f = 8'h00, dir_f = 8'h00;
  int          n_errors = 0, num_checks = 0;
  always #10 mclk = ~mclk;
  far_side_model u_far_side_model (.mclk(mclk), .sys_rst(sys_rst), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .cmp_c(cmp_c), .tx_line(tx_line), .sync_clock(sync_clock), .prog_out(prog_out));
  port_e_f_alternate_override u_port_e_f_alternate_override (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .legacy_mode(legacy),
    .scan_enable_fuse(fuse), .sleep_active(sleep), .prog_mode_active(prog), .timer_c_cmp_a_en(a_en),
    .timer_c_cmp_b_en(b_en), .timer_c_cmp_c_en(c_en), .timer_c_cmp_a_out(cmp_a), .timer_c_cmp_b_out(cmp_b),
    .timer_c_cmp_c_out(cmp_c), .timer_c_capture_in(cap), .timer_c_count_src(cnt), .ext_irq_enable(irq_en),
    .ext_irq_seven(i7), .ext_irq_six(i6), .ext_irq_five(i5), .ext_irq_four(i4), .serial_tx_enable(tx_en),
    .serial_rx_enable(rx_en), .serial_sync_select(sync), .serial_tx_line(tx_line),
    .serial_sync_clock(sync_clock), .serial_rx_line(rx_o), .serial_clock_in(clk_in),
    .prog_data_out(prog_out), .prog_data_in(prog_in), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
    .pe_pullup(pe_pu), .pf_in(pf_in), .pf_out(pf_out), .pf_oe(pf_oe), .pf_pullup(pf_pu));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon transfer; the request holds until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One test clock period; each phase outlasts the two-flop input sync.
  task automatic tck_step(input logic mode, input logic din);
    @(posedge mclk);
    pf_in[5] <= mode;
    pf_in[7] <= din;
    repeat (4) @(posedge mclk);
    pf_in[4] <= 1'b1;
    repeat (4) @(posedge mclk);
    pf_in[4] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  function automatic logic [23:0] exp_pe();
    logic [7:0] o, e, p;
    o = port_e;
    e = dir_e;
    p = port_e & ~dir_e & {8{~pu_off}};
    if (c_en && !legacy) o[5] = cmp_c;
    if (b_en && !legacy) o[4] = cmp_b;
    if (a_en && !legacy) o[3] = cmp_a;
    if (sync && !legacy) o[2] = sync_clock;
    if (tx_en) {o[1], e[1], p[1]} = {tx_line, 2'b10};
    if (rx_en) {e[0], p[0]} = {1'b0, port_e[0] & ~pu_off};
    return {o, e, p};
  endfunction
  function automatic logic [23:0] exp_pf();
    logic [7:0] e;
    e = legacy ? 8'h00 : dir_f;
    return {port_f, e, port_f & ~e & {8{~pu_off}}};
  endfunction

  initial begin
    void'($urandom(34291));
    repeat (3) @(posedge mclk);
    check("scan pullups in reset", {pf_pu[7], pf_pu[5], pf_pu[4]}, 3'b111);
    sys_rst <= 1'b0;
    fuse <= 1'b0;
    bus(1'b0, port_ef_pkg::OFS_PORT_E, 32'h0, rd);
    check("port e reset", rd, {24'h0, port_ef_pkg::PORT_RST});
    bus(1'b0, port_ef_pkg::OFS_DIR_F, 32'h0, rd);
    check("dir f reset", rd, {24'h0, port_ef_pkg::DIR_RST});
    bus(1'b0, port_ef_pkg::OFS_TAP, 32'h0, rd);
    check("tap reset", rd, {12'h0, port_ef_pkg::IR_RST, port_ef_pkg::TAP_RESET});
    bus(1'b1, 5'h02, 32'hFF, rd);
    bus(1'b0, 5'h02, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      {port_e, dir_e, port_f, dir_f} = $urandom;
      pu_off = 1'($urandom);
      bus(1'b1, port_ef_pkg::OFS_PORT_E, {24'h0, port_e}, rd);
      bus(1'b1, port_ef_pkg::OFS_DIR_E, {24'h0, dir_e}, rd);
      // Port F output levels change only here; legacy mode and the pull-up disable also change enables and pull-ups.
      bus(1'b1, port_ef_pkg::OFS_PORT_F, {24'h0, port_f}, rd);
      bus(1'b1, port_ef_pkg::OFS_DIR_F, {24'h0, dir_f}, rd);
      bus(1'b1, port_ef_pkg::OFS_CTRL, {31'h0, pu_off}, rd);
      repeat (4) begin
        @(posedge mclk);
        {legacy, a_en, b_en, c_en, tx_en, rx_en, sync} <= 7'($urandom);
        @(negedge mclk);
        check("pe pads", {8'h0, pe_out, pe_oe, pe_pu}, {8'h0, exp_pe()});
        check("pf pads", {8'h0, pf_out, pf_oe, pf_pu}, {8'h0, exp_pf()});
      end
    end
    $display("test overrides done");
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      pe_in <= 8'($urandom);
      {sleep, legacy} <= 2'(k);
      {irq_en, rx_en, sync} <= 6'b101011;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      g = sleep ? irq_en : 4'hF;
      check("irq inputs", {i7, i6, i5, i4}, pe_in[7:4] & g);
      check("timer inputs", {cap, cnt}, legacy ? 2'b00 : pe_in[7:6] & g[3:2]);
      check("rx input", rx_o, pe_in[0] & ~sleep);
      check("sync clock in", clk_in, pe_in[2] & ~legacy & ~sleep);
    end
    @(posedge mclk);
    {prog, sleep, tx_en} <= 3'b100;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("prog pins", {pe_out[1], prog_in}, {prog_out, pe_in[0]});
    $display("test inputs done");
    @(posedge mclk);
    {prog, legacy, fuse} <= 3'b001;
    tck_step(1'b0, 1'b0);
    tck_step(1'b1, 1'b0);
    tck_step(1'b1, 1'b0);
    tck_step(1'b0, 1'b0);
    tck_step(1'b0, 1'b0);
    bus(1'b0, port_ef_pkg::OFS_TAP, 32'h0, rd);
    check("tap shift ir", rd[15:0], port_ef_pkg::TAP_SHIR);
    check("tdo drive", pf_oe[6], 1'b1);
    check("tdo capture", pf_out[6], port_ef_pkg::IR_CAPTURE[0]);
    check("scan pins", {pf_oe[7], pf_oe[5], pf_oe[4], pf_pu[7], pf_pu[5], pf_pu[4]}, 6'b000111);
    for (int b = 0; b < 4; b++) tck_step(b == 3, b[0]);
    tck_step(1'b1, 1'b0);
    tck_step(1'b0, 1'b0);
    @(posedge mclk);
    pf_in[5] <= 1'b1;
    repeat (10) @(posedge mclk);
    bus(1'b0, port_ef_pkg::OFS_PIN_F, 32'h0, rd);
    check("scan pins read", rd, 32'h0);
    bus(1'b0, port_ef_pkg::OFS_TAP, 32'h0, rd);
    check("ir loaded idle", rd[19:0], {4'hA, port_ef_pkg::TAP_IDLE});
    check("tdo released", pf_oe[6], 1'b0);
    $display("test scan done");
    close_out();
  end
endmodule
`default_nettype wire
